/* pkg/brg_defines.vh */
// Constants for the bus-reset / gap-count control block.
// Assumes inclusion by bare name from the rtl files.
`ifndef BRG_DEFINES_VH
`define BRG_DEFINES_VH

// Register indices and AXI byte addresses (index times four)
`define BRG_IDX_CTRL       8'h01
`define BRG_IDX_SPEED      8'h08
`define BRG_ADDR_CTRL      8'h04
`define BRG_ADDR_SPEED     8'h20
`define BRG_ADDR_STATUS    8'h40
`define BRG_ADDR_PAGE      8'h44

// Control register fields
`define BRG_GAP_LSB        0
`define BRG_GAP_MSB        5
`define BRG_HOLDOFF_BIT    7
`define BRG_INIT_RESET_BIT 6

// Values
`define BRG_GAP_MAX        6'h3F
`define BRG_SPEED_S100     3'h0
`define BRG_SPEED_S200     3'h1
`define BRG_SPEED_S400     3'h2
`define BRG_SPEED_RST      `BRG_SPEED_S400
`define BRG_VENDOR_PAGE    3'h7
`define BRG_AXI_OKAY       2'h0
`define BRG_AXI_SLVERR     2'h2

// Bus-reset pulse length
`define BRG_RESET_NS       40
`define BRG_CLK_NS         4
`define BRG_RESET_CYC      ((`BRG_RESET_NS + `BRG_CLK_NS - 1) / `BRG_CLK_NS)

`endif

/* rtl/brg_gap_ctrl.v */
// Gap-count and root-holdoff storage with the repeated-reset rule.
// Assumes one-cycle load and bus-reset pulses on one clock.
`timescale 1ns/100ps
`default_nettype none
`include "brg_defines.vh"

module brg_gap_ctrl (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire       load_i,
  input  wire [5:0] gap_i,
  input  wire       holdoff_i,
  input  wire       bus_reset_i,
  output reg  [5:0] gap_o,
  output reg        holdoff_o
);

  // Set by any update without a reset start in the same cycle, cleared by every bus reset start, restarts included
  reg updated;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_o     <= `BRG_GAP_MAX;
      holdoff_o <= 1'b0;
      updated   <= 1'b0;
    end else if (load_i) begin
      gap_o     <= gap_i;
      holdoff_o <= holdoff_i;
      // A load meeting a reset start is used up by that very reset
      // write survives reset
      updated   <= !bus_reset_i;
    end else if (bus_reset_i) begin
      if (!updated)
        gap_o <= `BRG_GAP_MAX;
      updated <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* rtl/brg_reset_gen.v */
// Bus-reset sequencer: holds reset then runs an initialization phase.
// Assumes a one-cycle start pulse; restarts are honoured.
`timescale 1ns/100ps
`default_nettype none
`include "brg_defines.vh"

module brg_reset_gen #(
  parameter CYCLES = `BRG_RESET_CYC
) (
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire start_i,
  output reg  bus_reset_o,
  output reg  init_o,
  output reg  done_o
);

  localparam ST_IDLE = 2'b00;
  localparam ST_RST  = 2'b01;
  localparam ST_INIT = 2'b10;

  reg [1:0]  state;
  reg [15:0] count;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state       <= ST_IDLE;
      count       <= 16'h0000;
      bus_reset_o <= 1'b0;
      init_o      <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        state       <= ST_RST;
        count       <= CYCLES[15:0];
        bus_reset_o <= 1'b1;
        init_o      <= 1'b0;
      end else begin
        case (state)
          ST_RST: begin
            if (count == 16'h0001) begin
              state       <= ST_INIT;
              count       <= CYCLES[15:0];
              bus_reset_o <= 1'b0;
              init_o      <= 1'b1;
            end else begin
              count <= count - 16'h0001;
            end
          end
          ST_INIT: begin
            if (count == 16'h0001) begin
              state  <= ST_IDLE;
              init_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              count <= count - 16'h0001;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/brg_top.v */
// Bus-reset, gap-count and advertised link-speed control with AXI4-Lite registers.
// Assumes one clock; PHY-config and cable reset events are one-cycle pulses.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "brg_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module brg_top (
  input  wire        CLK_I,
  input  wire        RST_B_I,
  input  wire [7:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output reg         S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output reg         S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [7:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output reg         S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I,
  input  wire        CFG_RX_I,
  input  wire        CFG_TX_I,
  input  wire [5:0]  CFG_GAP_I,
  input  wire        CFG_HOLDOFF_I,
  input  wire        CABLE_RESET_I,
  output reg         BUS_RESET_O,
  output reg         BUS_INIT_O,
  output reg  [5:0]  GAP_COUNT_O,
  output reg         ROOT_HOLDOFF_O,
  output reg  [2:0]  SELFID_SPEED_O,
  output reg  [2:0]  PEER_SPEED_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched independently
  reg        aw_held;
  reg [7:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [2:0]  page_sel;
  reg [2:0]  link_speed;
  reg        sw_reset;
  reg        sw_load;
  reg [5:0]  sw_gap;
  reg        sw_holdoff;
  reg [7:0]  reset_count;

  wire       do_write = aw_held && w_held && !S_AXI_BVALID_O;
  wire       wr_ctrl  = do_write && (aw_addr == `BRG_ADDR_CTRL);
  wire       wr_speed = do_write && (aw_addr == `BRG_ADDR_SPEED) && (page_sel == `BRG_VENDOR_PAGE);
  wire       wr_page  = do_write && (aw_addr == `BRG_ADDR_PAGE);
  wire       wr_known = wr_ctrl || wr_speed || wr_page;

  wire [5:0] gap_q;
  wire       holdoff_q;
  wire       gen_reset;
  wire       gen_init;
  wire       gen_done;

  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_held         <= 1'b0;
      aw_addr         <= 8'h00;
      w_held          <= 1'b0;
      w_data          <= 32'h00000000;
      w_strb          <= 4'h0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `BRG_AXI_OKAY;
    end else begin
      S_AXI_AWREADY_O <= !aw_held && !S_AXI_AWREADY_O && S_AXI_AWVALID_I;
      S_AXI_WREADY_O  <= !w_held && !S_AXI_WREADY_O && S_AXI_WVALID_I;
      if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR_I[7:2], 2'b00};
      end
      if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_known ? `BRG_AXI_OKAY : `BRG_AXI_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register side effects
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      page_sel   <= 3'h0;
      link_speed <= `BRG_SPEED_RST;
      sw_reset   <= 1'b0;
      sw_load    <= 1'b0;
      sw_gap     <= `BRG_GAP_MAX;
      sw_holdoff <= 1'b0;
    end else begin
      sw_reset <= 1'b0;
      sw_load  <= 1'b0;
      if (wr_page && w_strb[0])
        page_sel <= w_data[2:0];
      if (wr_speed && w_strb[0])
        link_speed <= w_data[2:0];
      if (wr_ctrl && w_strb[0]) begin
        sw_load    <= 1'b1;
        sw_gap     <= w_data[`BRG_GAP_MSB:`BRG_GAP_LSB];
        sw_holdoff <= w_data[`BRG_HOLDOFF_BIT];
        sw_reset   <= w_data[`BRG_INIT_RESET_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gap storage and reset sequencing
  // packets also load
  wire       pkt_load     = CFG_RX_I || CFG_TX_I;
  wire       any_load     = sw_load || pkt_load;
  wire [5:0] load_gap     = sw_load ? sw_gap : CFG_GAP_I;
  wire       load_holdoff = sw_load ? sw_holdoff : CFG_HOLDOFF_I;
  wire       start_rst    = sw_reset || CABLE_RESET_I;

  // Every start counts as a bus reset, so a restart in mid-sequence
  // is still a second consecutive reset for the gap rule
  // six-bit gap field
  brg_gap_ctrl u_gap (
    .clk_i       (CLK_I),
    .rst_b_i     (RST_B_I),
    .load_i      (any_load),
    .gap_i       (load_gap),
    .holdoff_i   (load_holdoff),
    .bus_reset_i (start_rst),
    .gap_o       (gap_q),
    .holdoff_o   (holdoff_q)
  );

  brg_reset_gen u_rst (
    .clk_i       (CLK_I),
    .rst_b_i     (RST_B_I),
    .start_i     (start_rst),
    .bus_reset_o (gen_reset),
    .init_o      (gen_init),
    .done_o      (gen_done)
  );

  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      BUS_RESET_O    <= 1'b0;
      BUS_INIT_O     <= 1'b0;
      GAP_COUNT_O    <= `BRG_GAP_MAX;
      ROOT_HOLDOFF_O <= 1'b0;
      SELFID_SPEED_O <= `BRG_SPEED_RST;
      PEER_SPEED_O   <= `BRG_SPEED_S400;
      reset_count    <= 8'h00;
    end else begin
      BUS_RESET_O    <= gen_reset;
      BUS_INIT_O     <= gen_init;
      GAP_COUNT_O    <= gap_q;
      ROOT_HOLDOFF_O <= holdoff_q;
      SELFID_SPEED_O <= link_speed;
      PEER_SPEED_O   <= `BRG_SPEED_S400;
      if (gen_done)
        reset_count <= reset_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  reg [31:0] rd_mux;
  reg        rd_ok;

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    case ({S_AXI_ARADDR_I[7:2], 2'b00})
      `BRG_ADDR_CTRL:   rd_mux = {24'h000000, holdoff_q, 1'b0, gap_q};
      `BRG_ADDR_SPEED:  rd_mux = (page_sel == `BRG_VENDOR_PAGE) ? {29'h00000000, link_speed} : 32'h00000000;
      `BRG_ADDR_STATUS: rd_mux = {22'h000000, reset_count, gen_init, gen_reset};
      `BRG_ADDR_PAGE:   rd_mux = {29'h00000000, page_sel};
      default:          rd_ok  = 1'b0;
    endcase
  end

  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h00000000;
      S_AXI_RRESP_O   <= `BRG_AXI_OKAY;
    end else begin
      S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O && S_AXI_ARVALID_I;
      if (S_AXI_ARREADY_O && S_AXI_ARVALID_I) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O  <= rd_mux;
        S_AXI_RRESP_O  <= rd_ok ? `BRG_AXI_OKAY : `BRG_AXI_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* verification/brg_top_asserts.sv */
// Checker for the bus-reset and gap-count control block.
// Assumes binding to brg_top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "brg_defines.vh"
module brg_top_asserts (
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  input wire logic [7:0]  S_AXI_AWADDR_I,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        CFG_RX_I,
  input wire logic        CFG_TX_I,
  input wire logic [5:0]  CFG_GAP_I,
  input wire logic        CFG_HOLDOFF_I,
  input wire logic        CABLE_RESET_I,
  input wire logic        BUS_RESET_O,
  input wire logic        BUS_INIT_O,
  input wire logic [5:0]  GAP_COUNT_O,
  input wire logic        ROOT_HOLDOFF_O,
  input wire logic [2:0]  PEER_SPEED_O
);
  logic fresh;
  logic ctrl_wr;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////
  assign ctrl_wr = S_AXI_WVALID_I && S_AXI_WREADY_O && S_AXI_AWADDR_I == `BRG_ADDR_CTRL;
  // Gap loaded since the last reset start; a reset-bit write is used up by its own reset
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fresh <= 1'b0;
    end else if (CABLE_RESET_I) begin
      fresh <= 1'b0;
    end else if (CFG_RX_I || CFG_TX_I || ctrl_wr) begin
      fresh <= !(ctrl_wr && S_AXI_WDATA_I[`BRG_INIT_RESET_BIT]);
    end
  end
  chk_peer_s400: assert property (PEER_SPEED_O == `BRG_SPEED_S400)
    else $error("peer speed wrong");
  chk_rx_load: assert property (CFG_RX_I |-> ##2 {ROOT_HOLDOFF_O, GAP_COUNT_O} == $past({CFG_HOLDOFF_I, CFG_GAP_I}, 2))
    else $error("rx config not loaded");
  chk_tx_load: assert property (CFG_TX_I |-> ##2 {ROOT_HOLDOFF_O, GAP_COUNT_O} == $past({CFG_HOLDOFF_I, CFG_GAP_I}, 2))
    else $error("tx config not loaded");
  chk_bit_starts_reset: assert property (ctrl_wr && S_AXI_WDATA_I[`BRG_INIT_RESET_BIT] |-> ##[1:6] BUS_RESET_O)
    else $error("no bus reset after write");
  chk_keep_written: assert property (ctrl_wr |-> ##12 GAP_COUNT_O == $past(S_AXI_WDATA_I[5:0], 12))
    else $error("written gap lost");
  chk_cable_start: assert property (CABLE_RESET_I |-> ##[1:4] BUS_RESET_O)
    else $error("no bus reset after cable event");
  chk_force_max: assert property (CABLE_RESET_I && !CFG_RX_I && !CFG_TX_I && !fresh |-> ##[2:5] GAP_COUNT_O == `BRG_GAP_MAX)
    else $error("gap not forced to max");
  chk_reset_len: assert property ($rose(BUS_RESET_O) |-> BUS_RESET_O[*5] ##1 BUS_RESET_O[*5] ##1 BUS_INIT_O)
    else $error("reset phase length");
  chk_init_len: assert property ($fell(BUS_RESET_O) |-> BUS_INIT_O[*5] ##1 BUS_INIT_O[*5] ##1 !BUS_INIT_O)
    else $error("init phase length");
  chk_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read not answered");
  cover property ($rose(BUS_RESET_O));
  cover property (CFG_TX_I);
  cover property (CABLE_RESET_I && !fresh);
endmodule
bind brg_top brg_top_asserts chk_u (.*);
`default_nettype wire

/* verification/brg_peer_model.sv */
// Peer side: emits PHY-config packet and cable reset pulses on command.
// Assumes the bench drives go_i by non-blocking assignment at the clock edge.
`timescale 1ns/100ps
`default_nettype none
module brg_peer_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       go_i,
  input  wire logic [1:0] kind_i,
  input  wire logic [5:0] gap_i,
  input  wire logic       holdoff_i,
  output var  logic       cfg_rx_o,
  output var  logic       cfg_tx_o,
  output var  logic [5:0] cfg_gap_o,
  output var  logic       cfg_holdoff_o,
  output var  logic       cable_reset_o
);
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {cfg_rx_o, cfg_tx_o, cfg_gap_o, cfg_holdoff_o, cable_reset_o} <= 10'h000;
    end else begin
      cfg_rx_o      <= go_i && kind_i == 2'h0;
      cfg_tx_o      <= go_i && kind_i == 2'h1;
      cable_reset_o <= go_i && kind_i == 2'h2;
      // Fields invert every cycle off the pulse, so a stale value shows again on every second cycle
      cfg_gap_o     <= go_i ? gap_i : ~cfg_gap_o;
      cfg_holdoff_o <= go_i ? holdoff_i : ~cfg_holdoff_o;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Bench for brg_top: AXI4-Lite master plus peer event model.
// Assumes brg_defines.vh on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "brg_defines.vh"
module tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, go = 1'b0, mr = 1'b0, erhb;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h6A73, rd;
  logic [1:0]  kind = 2'h0;
  logic [5:0]  mg = 6'h00, egap;
  wire         awready, wready, bvalid, arready, rvalid, rx, tx, crhb, cab, brst, binit, root_holdoff_bit;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [5:0]  cgap, gap;
  wire  [2:0]  sid, peer;
  int          num_errors = 0, total_checks = 0, k;
  brg_top dut_u (.CLK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .CFG_RX_I(rx), .CFG_TX_I(tx),
    .CFG_GAP_I(cgap), .CFG_HOLDOFF_I(crhb), .CABLE_RESET_I(cab), .BUS_RESET_O(brst), .BUS_INIT_O(binit),
    .GAP_COUNT_O(gap), .ROOT_HOLDOFF_O(root_holdoff_bit), .SELFID_SPEED_O(sid), .PEER_SPEED_O(peer));
  brg_peer_model peer_u (.clk_i(clk), .rst_b_i(rst_b), .go_i(go), .kind_i(kind), .gap_i(mg), .holdoff_i(mr),
    .cfg_rx_o(rx), .cfg_tx_o(tx), .cfg_gap_o(cgap), .cfg_holdoff_o(crhb), .cable_reset_o(cab));
  initial forever #2 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ctrl_w(input logic r, input logic [5:0] g);
    return {24'h0, r, 1'b0, g};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, e);
  endtask
  task automatic rd_t(input logic [7:0] a, input logic [1:0] e);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rready <= 1'b0;
    chk(rresp, e);
  endtask
  task automatic ev(input logic [1:0] t, input logic [5:0] g, input logic r);
    @(posedge clk);
    go   <= 1'b1;
    kind <= t;
    mg   <= g;
    mr   <= r;
    @(posedge clk);
    go   <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd_t(`BRG_ADDR_CTRL, `BRG_AXI_OKAY);
    chk(rd, ctrl_w(1'b0, `BRG_GAP_MAX));
    wr(`BRG_ADDR_PAGE, 32'h7, `BRG_AXI_OKAY);
    rd_t(`BRG_ADDR_SPEED, `BRG_AXI_OKAY);
    chk(rd, `BRG_SPEED_S400);
    for (k = 0; k < 3; k++) begin
      wr(`BRG_ADDR_SPEED, 32'(k), `BRG_AXI_OKAY);
      rd_t(`BRG_ADDR_SPEED, `BRG_AXI_OKAY);
      chk(rd, 32'(k));
      chk(sid, 32'(k));
      chk(peer, `BRG_SPEED_S400);
    end
    wr(`BRG_ADDR_PAGE, 32'h0, `BRG_AXI_OKAY);
    wr(`BRG_ADDR_SPEED, 32'h0, `BRG_AXI_SLVERR);
    chk(sid, `BRG_SPEED_S400);
    rd_t(8'h10, `BRG_AXI_SLVERR);
    chk(rd, 32'h0);
    $display("test speed done");
    for (k = 0; k < 4; k++) begin
      rd = nxt();
      egap = (k == 0) ? 6'h00 : rd[5:0];
      erhb = rd[8];
      wr(`BRG_ADDR_CTRL, ctrl_w(erhb, egap) | 32'h40, `BRG_AXI_OKAY);
      repeat (30) @(posedge clk);
      chk(gap, egap);
      chk(root_holdoff_bit, erhb);
      rd_t(`BRG_ADDR_CTRL, `BRG_AXI_OKAY);
      chk(rd, ctrl_w(erhb, egap));
    end
    ev(2'h2, 6'h00, 1'b0);
    repeat (30) @(posedge clk);
    chk(gap, `BRG_GAP_MAX);
    $display("test register reset done");
    for (k = 0; k < 2; k++) begin
      rd = nxt();
      egap = {1'b0, rd[4:0]};
      erhb = rd[9];
      ev(k[1:0], egap, erhb);
      repeat (4) @(posedge clk);
      chk(gap, egap);
      chk(root_holdoff_bit, erhb);
      if (k == 0) begin
        ev(2'h2, 6'h00, 1'b0);
      end else begin
        rd_t(`BRG_ADDR_CTRL, `BRG_AXI_OKAY);
        wr(`BRG_ADDR_CTRL, rd | 32'h40, `BRG_AXI_OKAY);
      end
      repeat (30) @(posedge clk);
      chk(gap, egap);
      ev(2'h2, 6'h00, 1'b0);
      repeat (30) @(posedge clk);
      chk(gap, `BRG_GAP_MAX);
    end
    wr(`BRG_ADDR_CTRL, ctrl_w(erhb, `BRG_GAP_MAX) | 32'h40, `BRG_AXI_OKAY);
    repeat (30) @(posedge clk);
    chk(root_holdoff_bit, erhb);
    // Ten resets were started above; each must have run to its end
    rd_t(`BRG_ADDR_STATUS, `BRG_AXI_OKAY);
    chk(rd, 32'h00000028);
    $display("test config packet done");
    stop_test();
  end
endmodule
`default_nettype wire
